//--- rtl/tws_params.svh
// Offsets, field positions, reset values and clock ratios of the three-wire serial port
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH

`define TWS_ADDR_W 8
`define TWS_DATA_W 32

`define TWS_OFF_CTRL 8'h00
`define TWS_OFF_DATA 8'h04
`define TWS_OFF_PORT 8'h08
`define TWS_OFF_STAT 8'h0c
`define TWS_OFF_MASK 8'h10

`define TWS_CTRL_PIN_SEL 0
`define TWS_CTRL_CLK_LO 1
`define TWS_CTRL_CLK_HI 2
`define TWS_CTRL_FLOAT 3
`define TWS_CTRL_GO 4

`define TWS_PORT_OUT_LSB 0
`define TWS_PORT_DIR_LSB 4
`define TWS_PORT_PIN_LSB 8

`define TWS_STAT_DONE 0

`define TWS_CLK_EXT 2'h0
`define TWS_CLK_DIV16 2'h1
`define TWS_CLK_DIV128 2'h2
`define TWS_CLK_DIV1024 2'h3

`define TWS_DIV_16 16
`define TWS_DIV_128 128
`define TWS_DIV_1024 1024
`define TWS_HALF_W 10

`define TWS_BITS 4'h8
`define TWS_RST_PORT_OUT 3'h7
`define TWS_RST_PORT_DIR 3'h0
`define TWS_RST_SHIFT 8'h00

`endif

//--- rtl/tws_pkg.sv
// Types shared by the three-wire serial port files
package tws_pkg;
    typedef enum logic [0:0] {TWS_IDLE, TWS_RUN} tws_state_e;
    typedef logic [1:0] tws_clk_sel_t;
    typedef logic [2:0] tws_lines_t;
endpackage

//--- rtl/tws_sck_gen.sv
// Internal serial clock divider for the three-wire serial port
`timescale 1ns/1ps
`include "tws_params.svh"
module tws_sck_gen
    import tws_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic resetn, // Synchronous reset, active low
    input wire logic ce, // Clock enable
    input wire logic run, // Produce serial clock while high
    input wire tws_clk_sel_t div_sel, // Divider choice
    output logic sck_level, // Serial clock level, idles high
    output logic sck_fall, // One-cycle pulse at falling edge
    output logic sck_rise // One-cycle pulse at rising edge
);
    logic [`TWS_HALF_W-1:0] cnt_reg;
    logic [`TWS_HALF_W-1:0] half_last;
    logic wrap;

    // Half period minus one, in system clocks
    assign half_last = (div_sel == `TWS_CLK_DIV16) ? `TWS_HALF_W'(`TWS_DIV_16 / 2 - 1) :
                       (div_sel == `TWS_CLK_DIV128) ? `TWS_HALF_W'(`TWS_DIV_128 / 2 - 1) :
                       `TWS_HALF_W'(`TWS_DIV_1024 / 2 - 1);
    assign wrap = run && (cnt_reg == half_last);

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            cnt_reg <= '0;
            sck_level <= 1'b1;
            sck_fall <= 1'b0;
            sck_rise <= 1'b0;
        end
        else if (ce)
        begin
            // Stopped clock restarts from a full high half period
            cnt_reg <= (!run || wrap) ? '0 : cnt_reg + 1'b1;
            sck_level <= run ? (wrap ? ~sck_level : sck_level) : 1'b1;
            sck_fall <= wrap && sck_level;
            sck_rise <= wrap && !sck_level;
        end
    end
endmodule // tws_sck_gen

//--- rtl/tws_port.sv
// Three-wire serial port with APB registers, shared port lines and interrupt
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "tws_params.svh"
module tws_port
    import tws_pkg::*;
(
    input wire logic clk_sys, // System clock, 100 MHz
    input wire logic resetn, // Synchronous reset, active low
    input wire logic ce, // Clock enable, freezes all state when low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [`TWS_ADDR_W-1:0] paddr, // APB byte address
    input wire logic [`TWS_DATA_W-1:0] pwdata, // APB write data
    output logic [`TWS_DATA_W-1:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire tws_lines_t line_in, // Pin levels: 0 clock, 1 data out, 2 data in
    output tws_lines_t line_out, // Pin drive values
    output tws_lines_t line_oe, // Pin output enables, high drives
    output logic irq // Level interrupt
);
    tws_state_e state_reg;
    logic [7:0] serial_shift_reg;
    logic [3:0] bit_cnt_reg;
    logic serial_pin_select_reg;
    tws_clk_sel_t clk_sel_reg;
    logic output_float_select_reg;
    tws_lines_t port_out_reg;
    tws_lines_t port_dir_reg;
    logic status_reg;
    logic mask_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [`TWS_DATA_W-1:0] prdata_reg;
    tws_lines_t line_out_reg;
    tws_lines_t line_oe_reg;
    logic irq_reg;
    tws_lines_t sync1_reg;
    tws_lines_t sync2_reg;
    tws_lines_t sync3_reg;
    tws_lines_t pin_reg;
    logic ext_prev_reg;

    wire transfer_go = (state_reg == TWS_RUN);
    wire internal_clk = (clk_sel_reg != `TWS_CLK_EXT);
    wire apb_access = psel && penable;
    wire apb_done = apb_access && pready_reg;
    wire pready_next = apb_access && !pready_reg;
    wire hit_ctrl = (paddr == `TWS_OFF_CTRL);
    wire hit_data = (paddr == `TWS_OFF_DATA);
    wire hit_port = (paddr == `TWS_OFF_PORT);
    wire hit_stat = (paddr == `TWS_OFF_STAT);
    wire hit_mask = (paddr == `TWS_OFF_MASK);
    wire addr_hit = hit_ctrl || hit_data || hit_port || hit_stat || hit_mask;
    wire wr_en = apb_done && pwrite;
    wire wr_ctrl = wr_en && hit_ctrl;
    wire wr_data = wr_en && hit_data;
    wire wr_port = wr_en && hit_port;
    wire wr_stat = wr_en && hit_stat;
    wire wr_mask = wr_en && hit_mask;
    // Start needs the serial function selected in the same write
    wire start = wr_ctrl && !transfer_go && pwdata[`TWS_CTRL_GO] && pwdata[`TWS_CTRL_PIN_SEL];

    logic int_level;
    logic int_fall;
    logic int_rise;
    tws_sck_gen u_sck_gen
    (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ce(ce),
        .run(transfer_go && internal_clk),
        .div_sel(clk_sel_reg),
        .sck_level(int_level),
        .sck_fall(int_fall),
        .sck_rise(int_rise)
    );

    // Edges of the filtered external clock pin
    wire ext_fall = ext_prev_reg && !pin_reg[0];
    wire ext_rise = !ext_prev_reg && pin_reg[0];
    wire sck_fall = transfer_go && (internal_clk ? int_fall : ext_fall);
    wire sck_rise = transfer_go && (internal_clk ? int_rise : ext_rise);
    wire last_bit = sck_rise && (bit_cnt_reg == `TWS_BITS - 4'h1);
    wire stat_clear = wr_stat && pwdata[`TWS_STAT_DONE];

    wire [`TWS_DATA_W-1:0] ctrl_rd = {27'h0, transfer_go, output_float_select_reg, clk_sel_reg,
                                      serial_pin_select_reg};
    wire [`TWS_DATA_W-1:0] port_rd = {21'h0, pin_reg, 1'b0, port_dir_reg, 1'b0, port_out_reg};
    wire [`TWS_DATA_W-1:0] rd_mux = hit_ctrl ? ctrl_rd :
                                    hit_data ? {24'h0, serial_shift_reg} :
                                    hit_port ? port_rd :
                                    hit_stat ? {31'h0, status_reg} :
                                    hit_mask ? {31'h0, mask_reg} : '0;

    // Three-stage pin synchroniser; a change counts once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_sync
            always_ff @(posedge clk_sys)
            begin
                if (!resetn)
                begin
                    sync1_reg[gi] <= 1'b1;
                    sync2_reg[gi] <= 1'b1;
                    sync3_reg[gi] <= 1'b1;
                    pin_reg[gi] <= 1'b1;
                end
                else if (ce)
                begin
                    sync1_reg[gi] <= line_in[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                    sync3_reg[gi] <= sync2_reg[gi];
                    if (sync2_reg[gi] == sync3_reg[gi])
                        pin_reg[gi] <= sync3_reg[gi];
                end
            end
        end
    endgenerate

    // APB slave: one wait state, answer in the second access cycle
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end
        else if (ce)
        begin
            pready_reg <= pready_next;
            pslverr_reg <= pready_next && !addr_hit;
            prdata_reg <= (pready_next && !pwrite) ? rd_mux : '0;
        end
    end

    // Mode register, left alone while a transfer runs; mask and port direction bits written at any time
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            serial_pin_select_reg <= 1'b0;
            clk_sel_reg <= `TWS_CLK_EXT;
            output_float_select_reg <= 1'b0;
            mask_reg <= 1'b0;
            port_dir_reg <= `TWS_RST_PORT_DIR;
        end
        else if (ce)
        begin
            if (wr_ctrl && !transfer_go)
            begin
                serial_pin_select_reg <= pwdata[`TWS_CTRL_PIN_SEL];
                clk_sel_reg <= pwdata[`TWS_CTRL_CLK_HI:`TWS_CTRL_CLK_LO];
                output_float_select_reg <= pwdata[`TWS_CTRL_FLOAT];
            end
            if (wr_mask)
                mask_reg <= pwdata[`TWS_STAT_DONE];
            if (wr_port)
                port_dir_reg <= pwdata[`TWS_PORT_DIR_LSB +: 3];
        end
    end

    // Transfer sequencer
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            state_reg <= TWS_IDLE;
            bit_cnt_reg <= 4'h0;
        end
        else if (ce)
        begin
            case (state_reg)
                TWS_IDLE:
                begin
                    bit_cnt_reg <= 4'h0;
                    if (start)
                        state_reg <= TWS_RUN;
                end
                TWS_RUN:
                begin
                    if (sck_rise)
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    if (last_bit)
                        state_reg <= TWS_IDLE;
                end
                default:
                    state_reg <= TWS_IDLE;
            endcase
        end
    end

    // Shift register: plain register when idle, shifts on serial clock when running
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            serial_shift_reg <= `TWS_RST_SHIFT;
        else if (ce)
        begin
            if (sck_rise)
                serial_shift_reg <= {serial_shift_reg[6:0], pin_reg[2]};
            else if (wr_data && !transfer_go)
                serial_shift_reg <= pwdata[7:0];
        end
    end

    // Port latches; bit one doubles as the serial out latch
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            port_out_reg <= `TWS_RST_PORT_OUT;
        else if (ce)
        begin
            if (wr_port)
                port_out_reg <= pwdata[`TWS_PORT_OUT_LSB +: 3];
            // Shift edge beats a same-cycle port write so the frame is not corrupted
            if (sck_fall)
                port_out_reg[1] <= serial_shift_reg[7];
        end
    end

    // Done flag: a completing transfer wins over a same-cycle clear
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            status_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (last_bit)
                status_reg <= 1'b1;
            else if (start || stat_clear)
                status_reg <= 1'b0;
            irq_reg <= status_reg && mask_reg;
        end
    end

    // Pin drivers, registered so every pin comes from a flip-flop
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            line_out_reg <= `TWS_RST_PORT_OUT;
            line_oe_reg <= 3'h0;
            ext_prev_reg <= 1'b1;
        end
        else if (ce)
        begin
            ext_prev_reg <= pin_reg[0];
            line_out_reg[0] <= serial_pin_select_reg ? int_level : port_out_reg[0];
            line_out_reg[1] <= port_out_reg[1];
            line_out_reg[2] <= port_out_reg[2];
            line_oe_reg[0] <= serial_pin_select_reg ? internal_clk : port_dir_reg[0];
            line_oe_reg[1] <= serial_pin_select_reg ? !output_float_select_reg : port_dir_reg[1];
            line_oe_reg[2] <= serial_pin_select_reg ? 1'b0 : port_dir_reg[2];
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign line_out = line_out_reg;
    assign line_oe = line_oe_reg;
    assign irq = irq_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    chk_go_start: assert property (ce && start |=> transfer_go && !status_reg)
        else $error("start did not begin transfer or clear done flag");
    chk_done_set: assert property (ce && last_bit |=> !transfer_go && status_reg)
        else $error("eighth clock did not end transfer");
    chk_bit_count: assert property (bit_cnt_reg <= `TWS_BITS)
        else $error("bit counter ran past eight");
    chk_msb_out: assert property (ce && sck_fall |=> port_out_reg[1] == $past(serial_shift_reg[7]))
        else $error("serial out not loaded from shift msb");
    chk_shift_in: assert property (ce && sck_rise |=>
        serial_shift_reg == {$past(serial_shift_reg[6:0]), $past(pin_reg[2])})
        else $error("shift did not take serial in at lsb");
    chk_idle_hold: assert property (ce && !transfer_go && !wr_data |=> $stable(serial_shift_reg))
        else $error("idle shift register changed");
    chk_float_so: assert property (ce && serial_pin_select_reg && output_float_select_reg |=> !line_oe[1])
        else $error("serial out driven in receive only mode");
    chk_duplex_so: assert property (ce && serial_pin_select_reg && !output_float_select_reg |=> line_oe[1])
        else $error("serial out not driven in duplex mode");
    chk_clk_drive: assert property (ce && serial_pin_select_reg |=> line_oe[0] == $past(internal_clk))
        else $error("clock line drive does not follow clock source");
    chk_port_mode: assert property (ce && !serial_pin_select_reg |=> line_oe == $past(port_dir_reg))
        else $error("port mode drive not from direction bits");
    chk_ext_edge: assert property (sck_rise && !internal_clk |-> pin_reg[0] && !ext_prev_reg)
        else $error("external edge not from filtered pin");
    chk_irq_level: assert property (ce |=> irq == $past(status_reg && mask_reg))
        else $error("interrupt not following masked status");
    chk_apb_wait: assert property (ce && apb_access && !pready |=> pready)
        else $error("apb answer missing");

    cov_duplex: cover property (transfer_go && !output_float_select_reg && last_bit);
    cov_receive: cover property (transfer_go && output_float_select_reg && last_bit);
    cov_external: cover property (transfer_go && !internal_clk && last_bit);
    cov_set_clear: cover property (last_bit && stat_clear);
endmodule // tws_port

//--- test/tws_peer.sv
// Peripheral model on the far side of the three-wire serial link
`timescale 1ns/1ps
module tws_peer (
    input wire logic clk_sys, // System clock
    input wire logic sck, // Serial clock line level
    input wire logic so, // Serial data from the port
    input wire logic load, // Take a new byte to send
    input wire logic [7:0] tx_byte, // Byte to send
    input wire logic ext_go, // Supply eight serial clocks
    output logic si, // Serial data to the port
    output logic sck_drv, // Own serial clock, idles high
    output logic [7:0] rx_byte // Last byte received
);
    logic sck_q = 1'b1;
    logic [7:0] tx_reg = 8'h00;
    int half = 0;
    int edges = 0;

    initial
    begin
        si = 1'b1;
        sck_drv = 1'b1;
        rx_byte = 8'h00;
    end

    always @(posedge clk_sys)
    begin
        sck_q <= sck;
        if (load)
            tx_reg <= tx_byte;
        else if (sck_q && !sck)
        begin
            si <= tx_reg[7];
            tx_reg <= {tx_reg[6:0], 1'b0};
        end
        if (!sck_q && sck)
            rx_byte <= {rx_byte[6:0], so};
        // Half period of 12 leaves margin over the port's input filter
        if (ext_go)
            edges <= 16;
        else if (edges > 0)
        begin
            if (half == 11)
            begin
                half <= 0;
                sck_drv <= ~sck_drv;
                edges <= edges - 1;
            end
            else
                half <= half + 1;
        end
    end
endmodule // tws_peer

//--- test/three_wire_serial_port_tb.sv
// Self-checking bench for the three-wire serial port
`timescale 1ns/1ps
`include "tws_params.svh"
module three_wire_serial_port_tb;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [2:0] line_out;
    logic [2:0] line_oe;
    logic [2:0] line_in;
    logic si;
    logic sck_drv;
    logic ce = 1'b1;
    logic load = 1'b0;
    logic ext_go = 1'b0;
    logic [7:0] tx_byte = 8'h00;
    logic [7:0] rx_byte;
    logic [31:0] rd;
    logic er;
    int mismatches = 0;
    int checks = 0;
    int lowcnt = 0;
    int lowlen = 0;
    int exp_q[$];

    always #5 clk_sys = ~clk_sys;
    // Released serial out line sits at its pull-up
    assign line_in[0] = line_oe[0] ? line_out[0] : sck_drv;
    assign line_in[1] = line_oe[1] ? line_out[1] : 1'b1;
    assign line_in[2] = line_oe[2] ? line_out[2] : si;

    tws_port u_dut (.clk_sys(clk_sys), .resetn(resetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .line_in(line_in), .line_out(line_out), .line_oe(line_oe), .irq(irq));
    tws_peer u_peer (.clk_sys(clk_sys), .sck(line_in[0]), .so(line_in[1]), .load(load),
        .tx_byte(tx_byte), .ext_go(ext_go), .si(si), .sck_drv(sck_drv), .rx_byte(rx_byte));

    always @(posedge clk_sys)
    begin
        // Frozen cycles do not lengthen the measured half period
        if (line_oe[0] && !line_out[0])
            lowcnt <= lowcnt + (ce ? 1 : 0);
        else
        begin
            if (lowcnt != 0)
                lowlen <= lowcnt;
            lowcnt <= 0;
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do
            @(posedge clk_sys);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, er);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rd, er);
        chk($sformatf("reg %h", a), rd & m, exp);
    endtask

    task automatic xfer(input logic [1:0] sel, input logic fl);
        logic [7:0] d;
        logic [7:0] p;
        logic [2:0] o;
        int n;
        int flips;
        int m;
        int sent;
        int i;
        d = 8'($urandom);
        p = 8'($urandom);
        n = 0;
        flips = 0;
        // Bit model: msb leaves on the fall, serial in enters the lsb on the rise
        m = d;
        sent = 0;
        for (i = 0; i < 8; i++)
        begin
            sent = (sent << 1) | ((m >> 7) & 1);
            m = ((m << 1) | p[7 - i]) & 32'hff;
        end
        exp_q.push_back(m);
        exp_q.push_back(sent);
        wr(`TWS_OFF_DATA, {24'h0, d});
        tx_byte <= p;
        load <= 1'b1;
        ext_go <= (sel == `TWS_CLK_EXT);
        @(posedge clk_sys);
        load <= 1'b0;
        ext_go <= 1'b0;
        wr(`TWS_OFF_CTRL, {27'h0, 1'b1, fl, sel, 1'b1});
        rchk(`TWS_OFF_STAT, 32'h1, 32'h0);
        if (fl)
        begin
            chk("so enable", {31'h0, line_oe[1]}, 32'h0);
            // Freeze mid-frame; a running clock line would toggle every 8 cycles
            ce <= 1'b0;
            @(posedge clk_sys);
            o = line_out;
            repeat (24)
            begin
                @(posedge clk_sys);
                if (line_out !== o)
                    flips++;
            end
            ce <= 1'b1;
            chk("ce freeze", flips, 0);
        end
        do
        begin
            apb(1'b0, `TWS_OFF_CTRL, 32'h0, rd, er);
            n++;
        end
        while (rd[4] !== 1'b0 && n < 5000);
        chk("go cleared", {31'h0, rd[4]}, 32'h0);
        rchk(`TWS_OFF_DATA, 32'hff, exp_q.pop_front());
        sent = exp_q.pop_front();
        if (!fl)
            chk("peer rx", {24'h0, rx_byte}, sent);
        rchk(`TWS_OFF_STAT, 32'h1, 32'h1);
        chk("irq", {31'h0, irq}, 32'h1);
        if (sel != `TWS_CLK_EXT)
            chk("sck low", lowlen, (sel == 2'h1) ? 8 : (sel == 2'h2) ? 64 : 512);
    endtask

    initial
    begin
        void'($urandom(32'h82033e4b));
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        rchk(`TWS_OFF_CTRL, 32'h1f, 32'h0);
        rchk(`TWS_OFF_PORT, 32'h77, 32'h07);
        rchk(`TWS_OFF_STAT, 32'h1, 32'h0);
        apb(1'b0, 8'h14, 32'h0, rd, er);
        chk("unmapped err", {31'h0, er}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        wr(`TWS_OFF_DATA, 32'h5a);
        rchk(`TWS_OFF_DATA, 32'hff, 32'h5a);
        wr(`TWS_OFF_MASK, 32'h1);
        xfer(`TWS_CLK_DIV16, 1'b0);
        xfer(`TWS_CLK_DIV128, 1'b0);
        xfer(`TWS_CLK_DIV1024, 1'b0);
        xfer(`TWS_CLK_EXT, 1'b0);
        xfer(`TWS_CLK_DIV16, 1'b1);
        wr(`TWS_OFF_MASK, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(`TWS_OFF_MASK, 32'h1);
        repeat (2) @(posedge clk_sys);
        chk("irq unmasked", {31'h0, irq}, 32'h1);
        wr(`TWS_OFF_STAT, 32'h1);
        repeat (2) @(posedge clk_sys);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        wr(`TWS_OFF_CTRL, 32'h0);
        wr(`TWS_OFF_PORT, 32'h75);
        repeat (2) @(posedge clk_sys);
        chk("port out", {29'h0, line_out}, 32'h5);
        chk("port oe", {29'h0, line_oe}, 32'h7);
        wr(`TWS_OFF_CTRL, 32'h1);
        repeat (2) @(posedge clk_sys);
        chk("so latch", {30'h0, line_oe[1], line_out[1]}, 32'h2);
        stop_test();
    end

    initial
    begin
        repeat (60000) @(posedge clk_sys);
        mismatches++;
        stop_test();
    end
endmodule // three_wire_serial_port_tb
